/* rtl/usb_irq_pkg.sv */
package usb_irq_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_TOP_STATUS = 8'h00;
	localparam logic [7:0] IDX_DEVICE_STATUS = 8'h01;
	localparam logic [7:0] IDX_HOST_STATUS = 8'h02;
	localparam logic [7:0] IDX_CPU_STATUS = 8'h03;
	localparam logic [7:0] IDX_FIFO_STATUS = 8'h04;
	localparam logic [7:0] IDX_MAIN_ENABLE = 8'h08;
	localparam logic [7:0] IDX_DEVICE_ENABLE = 8'h09;
	localparam logic [7:0] IDX_HOST_ENABLE = 8'h0a;
	localparam logic [7:0] IDX_CPU_ENABLE = 8'h0b;
	localparam logic [7:0] IDX_FIFO_ENABLE = 8'h0c;
	localparam logic [7:0] IDX_FRAME_ENABLE = 8'h18;
	localparam logic [7:0] IDX_CH0_ENABLE = 8'h19;
	localparam logic [7:0] IDX_CHR_ENABLE = 8'h1a;
	localparam logic [7:0] IDX_CONTROL = 8'h1c;
	localparam logic [7:0] IDX_QUANTITY = 8'h1d;
	localparam logic [7:0] IDX_COUNTER = 8'h1e;

	localparam int CPU_RAM_BIT = 7;
	localparam int CPU_WRAP_BIT = 1;
	localparam int CPU_DMA_BIT = 0;
	localparam int FIFO_DMA_BIT = 7;
	localparam int FIFO_DATA_BIT = 2;
	localparam int FIFO_FULL_BIT = 1;
	localparam int FIFO_EMPTY_BIT = 0;
	localparam int TOP_DEVICE_BIT = 7;
	localparam int TOP_HOST_BIT = 6;
	localparam int TOP_CPU_BIT = 5;
	localparam int TOP_FIFO_BIT = 4;
	localparam int TOP_PM_BIT = 0;
	localparam int HOST_FRAME_BIT = 3;
	localparam int HOST_CH0_BIT = 1;
	localparam int HOST_CHR_BIT = 0;

	localparam int CTL_ROLE_BIT = 0;
	localparam int CTL_FREE_RUN_BIT = 1;
	localparam int CTL_START_BIT = 2;
	localparam int CTL_STOP_BIT = 3;
	localparam int CTL_BUSY_BIT = 4;
	localparam int CTL_SEL_LSB = 8;

	// Implemented bits of each 8-bit register
	localparam logic [7:0] CPU_STATUS_MASK = 8'h83;
	localparam logic [7:0] FIFO_STATUS_MASK = 8'h87;
	localparam logic [7:0] MAIN_ENABLE_MASK = 8'hf1;
	localparam logic [7:0] DEVICE_ENABLE_MASK = 8'hbb;
	localparam logic [7:0] HOST_ENABLE_MASK = 8'hfb;
	localparam logic [7:0] CPU_ENABLE_MASK = 8'h83;
	localparam logic [7:0] FIFO_ENABLE_MASK = 8'h87;

	// Enable bits that stay effective in sleep
	localparam logic [7:0] MAIN_SLEEP_MASK = 8'hc1;
	localparam logic [7:0] DEVICE_SLEEP_MASK = 8'ha0;
	localparam logic [7:0] HOST_SLEEP_MASK = 8'hc0;

	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;
	localparam logic [31:0] COUNT_TOP = 32'hffff_ffff;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {DMA_IDLE, DMA_RUN, DMA_ENDING} dma_state_t;

	typedef struct packed {
		logic awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [DATA_W-1:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [ADDR_W-1:0] araddr;
		logic rready;
	} axil_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0] rresp;
	} axil_rsp_t;

endpackage

/* rtl/usb_ctrl_interrupt_aggregator.sv */
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
// Behaviour
// - Host frame, channel-0, other-channel summaries read 1 when enabled leaf factor pending.
// - CPU-interface and FIFO status bits clear on writing 1; writing 0 keeps them.
// - RAM fetch completion sets the RAM fetch done flag.
// - Free-run counter overflow sets the transfer counter wrap flag.
// - On free-run overflow the counter wraps to zero and transfer continues.
// - DMA stop, or quantity moved plus end processing done, sets DMA complete.
// - Device role: IN endpoint flags after DMA end and drain; OUT at DMA end.
// - Host role: OUT channel flags after DMA end and drain; IN at DMA end.
// - Watched area holding data sets the buffer has data flag.
// - Watched area becoming full sets the FIFO full flag.
// - Watched area becoming empty sets the FIFO empty flag.
// - Main status factor drives the interrupt line only if its main enable allows.
// - Enable bit 1 passes its factor, 0 blocks it.
// - In sleep, main device, host and power done enables stay effective.
// - Device, host and CPU group enables gate leaves into main summary bits.
// - In sleep, bus power change and device engine enables stay effective.
// - In sleep, bus power fault and line change enables stay effective.
// - Summary bits are read-only and fall once underlying leaves clear.
module usb_ctrl_interrupt_aggregator #(
	parameter int AREAS = 6
) (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire usb_irq_pkg::axil_req_t axil_req_i,
	output usb_irq_pkg::axil_rsp_t axil_rsp_o,
	input wire logic sleep_i,
	input wire logic pm_done_i,
	input wire logic [7:0] device_status_i,
	input wire logic [3:0] host_direct_i,
	input wire logic [7:0] host_frame_leaf_i,
	input wire logic [7:0] host_ch0_leaf_i,
	input wire logic [7:0] host_chr_leaf_i,
	input wire logic ram_fetch_done_i,
	input wire logic dma_beat_i,
	input wire logic dma_stop_i,
	input wire logic dma_end_done_i,
	input wire logic joined_in_dir_i,
	input wire logic joined_fifo_empty_i,
	input wire logic [AREAS-1:0] area_has_data_i,
	input wire logic [AREAS-1:0] area_full_i,
	input wire logic [AREAS-1:0] area_empty_i,
	output logic dma_active_o,
	output logic irq_out_n_o
);
	import usb_irq_pkg::*;

	if (AREAS < 1 || AREAS > 8) begin : g_check
		$error("AREAS must lie between 1 and 8");
	end

	function automatic logic [7:0] byte_idx(input logic [ADDR_W-1:0] addr);
		return {2'b00, addr[ADDR_W-1:2]};
	endfunction

	function automatic logic is_mapped(input logic [7:0] idx);
		case (idx)
			IDX_TOP_STATUS, IDX_DEVICE_STATUS, IDX_HOST_STATUS, IDX_CPU_STATUS,
			IDX_FIFO_STATUS, IDX_MAIN_ENABLE, IDX_DEVICE_ENABLE, IDX_HOST_ENABLE,
			IDX_CPU_ENABLE, IDX_FIFO_ENABLE, IDX_FRAME_ENABLE, IDX_CH0_ENABLE,
			IDX_CHR_ENABLE, IDX_CONTROL, IDX_QUANTITY, IDX_COUNTER: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	// Any factor whose enable is set
	function automatic logic hit(input logic [7:0] stat, input logic [7:0] en);
		return |(stat & en);
	endfunction

	// Bus slave state
	logic aw_held, w_held, awready, wready, bvalid, arready, rvalid;
	logic [ADDR_W-1:0] aw_addr;
	logic [DATA_W-1:0] w_data, rdata;
	logic [3:0] w_strb;
	logic [1:0] bresp, rresp;

	// Registers
	logic [7:0] cpu_status, fifo_status, main_enable, device_enable, host_enable;
	logic [7:0] cpu_enable, fifo_enable, frame_enable, ch0_enable, chr_enable;
	logic role_select, free_run;
	logic [AREAS-1:0] area_watch_select;
	logic [31:0] quantity, counter;
	dma_state_t dma_state;

	logic draining;
	logic [AREAS-1:0] full_seen;
	logic [AREAS-1:0] empty_seen;

	logic aw_take, w_take, ar_take, wr_fire, wr_lane0;
	logic [7:0] wr_idx, wr_byte, rd_idx;
	logic [DATA_W-1:0] rd_word;

	dma_state_t next_dma_state;
	logic [31:0] next_counter;
	logic wrap_evt, cmp_evt, start_pulse, stop_pulse, need_drain, fifo_dma_evt;
	logic [7:0] cpu_set, cpu_clr, fifo_set, fifo_clr;
	logic [7:0] host_status_view;
	logic [7:0] device_status_view;
	logic [7:0] top_status;
	logic [7:0] main_eff;
	logic [7:0] device_eff;
	logic [7:0] host_eff;
	logic [AREAS-1:0] watched_full;
	logic [AREAS-1:0] watched_empty;

	assign axil_rsp_o = '{awready: awready, wready: wready, bvalid: bvalid, bresp: bresp,
		arready: arready, rvalid: rvalid, rdata: rdata, rresp: rresp};

	assign aw_take = axil_req_i.awvalid && awready;
	assign w_take = axil_req_i.wvalid && wready;
	assign ar_take = axil_req_i.arvalid && arready;
	assign wr_fire = aw_held && w_held && !bvalid;
	assign wr_idx = byte_idx(aw_addr);
	assign wr_lane0 = w_strb[0];
	assign wr_byte = w_data[7:0];
	assign rd_idx = byte_idx(axil_req_i.araddr);

	// Write address and data taken in either order
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
			w_held <= 1'b0;
			w_data <= '0;
			w_strb <= 4'h0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_held <= 1'b1;
				aw_addr <= axil_req_i.awaddr;
			end else if (wr_fire) begin
				aw_held <= 1'b0;
			end
			if (w_take) begin
				w_held <= 1'b1;
				w_data <= axil_req_i.wdata;
				w_strb <= axil_req_i.wstrb;
			end else if (wr_fire) begin
				w_held <= 1'b0;
			end
			awready <= !(aw_take || aw_held || bvalid);
			wready <= !(w_take || w_held || bvalid);
			if (wr_fire) begin
				bvalid <= 1'b1;
				bresp <= is_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid && axil_req_i.bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// Read channel, data one edge after the address is taken
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= RESP_OKAY;
		end else if (ar_take) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_word;
			rresp <= is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && axil_req_i.rready) begin
			rvalid <= 1'b0;
		end else if (!rvalid) begin
			arready <= 1'b1;
		end
	end

	// Enable and control registers
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			main_enable <= REG_RESET;
			device_enable <= REG_RESET;
			host_enable <= REG_RESET;
			cpu_enable <= REG_RESET;
			fifo_enable <= REG_RESET;
			frame_enable <= REG_RESET;
			ch0_enable <= REG_RESET;
			chr_enable <= REG_RESET;
			role_select <= 1'b0;
			free_run <= 1'b0;
			area_watch_select <= '0;
			quantity <= WORD_RESET;
		end else if (wr_fire) begin
			if (wr_lane0) begin
				case (wr_idx)
					IDX_MAIN_ENABLE: main_enable <= wr_byte & MAIN_ENABLE_MASK;
					IDX_DEVICE_ENABLE: device_enable <= wr_byte & DEVICE_ENABLE_MASK;
					IDX_HOST_ENABLE: host_enable <= wr_byte & HOST_ENABLE_MASK;
					IDX_CPU_ENABLE: cpu_enable <= wr_byte & CPU_ENABLE_MASK;
					IDX_FIFO_ENABLE: fifo_enable <= wr_byte & FIFO_ENABLE_MASK;
					IDX_FRAME_ENABLE: frame_enable <= wr_byte;
					IDX_CH0_ENABLE: ch0_enable <= wr_byte;
					IDX_CHR_ENABLE: chr_enable <= wr_byte;
					IDX_CONTROL: begin
						role_select <= w_data[CTL_ROLE_BIT];
						free_run <= w_data[CTL_FREE_RUN_BIT];
					end
					default: ;
				endcase
			end
			if (wr_idx == IDX_CONTROL && w_strb[1]) begin
				area_watch_select <= w_data[CTL_SEL_LSB +: AREAS];
			end
			if (wr_idx == IDX_QUANTITY) begin
				for (int b = 0; b < 4; b++) begin
					if (w_strb[b]) begin
						quantity[8*b +: 8] <= w_data[8*b +: 8];
					end
				end
			end
		end
	end

	assign start_pulse = wr_fire && wr_lane0 && wr_idx == IDX_CONTROL && w_data[CTL_START_BIT];
	assign stop_pulse = wr_fire && wr_lane0 && wr_idx == IDX_CONTROL && w_data[CTL_STOP_BIT];

	// Transfer counter and DMA progress
	always_comb begin
		next_dma_state = dma_state;
		next_counter = counter;
		wrap_evt = 1'b0;
		cmp_evt = 1'b0;
		case (dma_state)
			DMA_IDLE: begin
				if (start_pulse) begin
					next_dma_state = DMA_RUN;
					next_counter = WORD_RESET;
				end
			end
			DMA_RUN: begin
				if (stop_pulse || dma_stop_i) begin
					next_dma_state = DMA_IDLE;
					cmp_evt = 1'b1;
				end else if (dma_beat_i) begin
					next_counter = counter + 32'h1;
					if (free_run) begin
						wrap_evt = counter == COUNT_TOP;
					end else if (next_counter == quantity) begin
						next_dma_state = DMA_ENDING;
					end
				end
			end
			DMA_ENDING: begin
				if (stop_pulse || dma_stop_i || dma_end_done_i) begin
					next_dma_state = DMA_IDLE;
					cmp_evt = 1'b1;
				end
			end
			default: next_dma_state = DMA_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dma_state <= DMA_IDLE;
			counter <= WORD_RESET;
			dma_active_o <= 1'b0;
		end else begin
			dma_state <= next_dma_state;
			counter <= next_counter;
			dma_active_o <= next_dma_state == DMA_RUN;
		end
	end

	// Drain wait for joined FIFO after DMA end
	assign need_drain = role_select ? !joined_in_dir_i : joined_in_dir_i;
	assign fifo_dma_evt = (cmp_evt && !need_drain) || (draining && joined_fifo_empty_i);

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			draining <= 1'b0;
		end else if (cmp_evt && need_drain) begin
			draining <= 1'b1;
		end else if (joined_fifo_empty_i) begin
			draining <= 1'b0;
		end
	end

	// Edge detection of watched areas
	assign watched_full = area_watch_select & area_full_i;
	assign watched_empty = area_watch_select & area_empty_i;

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			full_seen <= '0;
			empty_seen <= '0;
		end else begin
			full_seen <= watched_full;
			empty_seen <= watched_empty;
		end
	end

	// Sticky leaf flags, set wins over clear
	always_comb begin
		cpu_set = 8'h00;
		cpu_set[CPU_RAM_BIT] = ram_fetch_done_i;
		cpu_set[CPU_WRAP_BIT] = wrap_evt;
		cpu_set[CPU_DMA_BIT] = cmp_evt;
		fifo_set = 8'h00;
		fifo_set[FIFO_DMA_BIT] = fifo_dma_evt;
		fifo_set[FIFO_DATA_BIT] = |(area_watch_select & area_has_data_i);
		fifo_set[FIFO_FULL_BIT] = |(watched_full & ~full_seen);
		fifo_set[FIFO_EMPTY_BIT] = |(watched_empty & ~empty_seen);
		cpu_clr = 8'h00;
		fifo_clr = 8'h00;
		if (wr_fire && wr_lane0 && wr_idx == IDX_CPU_STATUS) begin
			cpu_clr = wr_byte;
		end
		if (wr_fire && wr_lane0 && wr_idx == IDX_FIFO_STATUS) begin
			fifo_clr = wr_byte;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cpu_status <= REG_RESET;
			fifo_status <= REG_RESET;
		end else begin
			cpu_status <= ((cpu_status & ~cpu_clr) | cpu_set) & CPU_STATUS_MASK;
			fifo_status <= ((fifo_status & ~fifo_clr) | fifo_set) & FIFO_STATUS_MASK;
		end
	end

	// Sleep keeps only the wake-capable enables
	assign main_eff = sleep_i ? main_enable & MAIN_SLEEP_MASK : main_enable;
	assign device_eff = sleep_i ? device_enable & DEVICE_SLEEP_MASK : device_enable;
	assign host_eff = sleep_i ? host_enable & HOST_SLEEP_MASK : host_enable;

	// Summaries follow their leaves combinationally
	always_comb begin
		host_status_view = {host_direct_i, 4'h0};
		host_status_view[HOST_FRAME_BIT] = hit(host_frame_leaf_i, frame_enable);
		host_status_view[HOST_CH0_BIT] = hit(host_ch0_leaf_i, ch0_enable);
		host_status_view[HOST_CHR_BIT] = hit(host_chr_leaf_i, chr_enable);
		device_status_view = device_status_i & DEVICE_ENABLE_MASK;
		top_status = 8'h00;
		top_status[TOP_DEVICE_BIT] = hit(device_status_view, device_eff);
		top_status[TOP_HOST_BIT] = hit(host_status_view, host_eff);
		top_status[TOP_CPU_BIT] = hit(cpu_status, cpu_enable);
		top_status[TOP_FIFO_BIT] = hit(fifo_status, fifo_enable);
		top_status[TOP_PM_BIT] = pm_done_i;
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_out_n_o <= 1'b1;
		end else begin
			irq_out_n_o <= !hit(top_status, main_eff);
		end
	end

	// Read mux; summaries and reserved bits are read-only
	always_comb begin
		rd_word = '0;
		case (rd_idx)
			IDX_TOP_STATUS: rd_word[7:0] = top_status;
			IDX_DEVICE_STATUS: rd_word[7:0] = device_status_view;
			IDX_HOST_STATUS: rd_word[7:0] = host_status_view;
			IDX_CPU_STATUS: rd_word[7:0] = cpu_status;
			IDX_FIFO_STATUS: rd_word[7:0] = fifo_status;
			IDX_MAIN_ENABLE: rd_word[7:0] = main_enable;
			IDX_DEVICE_ENABLE: rd_word[7:0] = device_enable;
			IDX_HOST_ENABLE: rd_word[7:0] = host_enable;
			IDX_CPU_ENABLE: rd_word[7:0] = cpu_enable;
			IDX_FIFO_ENABLE: rd_word[7:0] = fifo_enable;
			IDX_FRAME_ENABLE: rd_word[7:0] = frame_enable;
			IDX_CH0_ENABLE: rd_word[7:0] = ch0_enable;
			IDX_CHR_ENABLE: rd_word[7:0] = chr_enable;
			IDX_CONTROL: begin
				rd_word[CTL_ROLE_BIT] = role_select;
				rd_word[CTL_FREE_RUN_BIT] = free_run;
				rd_word[CTL_BUSY_BIT] = dma_state != DMA_IDLE;
				rd_word[CTL_SEL_LSB +: AREAS] = area_watch_select;
			end
			IDX_QUANTITY: rd_word = quantity;
			IDX_COUNTER: rd_word = counter;
			default: rd_word = '0;
		endcase
	end

endmodule

/* tb/usb_ctrl_interrupt_aggregator_checker.sv */
`timescale 1ns/100ps
module usb_irq_aggregator_checker (
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire usb_irq_pkg::axil_req_t axil_req_i,
	input wire usb_irq_pkg::axil_rsp_t axil_rsp_o,
	input wire logic dma_stop_i,
	input wire logic dma_active_o,
	input wire logic irq_out_n_o
);
	import usb_irq_pkg::*;
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	chk_write_answer: assert property (
		axil_req_i.awvalid && axil_rsp_o.awready && axil_req_i.wvalid && axil_rsp_o.wready
		|-> ##2 axil_rsp_o.bvalid)
		else $error("no write response");
	chk_b_single: assert property (
		axil_rsp_o.bvalid && axil_req_i.bready |=> !axil_rsp_o.bvalid)
		else $error("write response repeated");
	chk_ready_back: assert property (
		axil_rsp_o.bvalid && axil_req_i.bready |-> ##[1:3] axil_rsp_o.awready && axil_rsp_o.wready)
		else $error("write ready not restored");
	chk_read_answer: assert property (
		axil_req_i.arvalid && axil_rsp_o.arready |=> axil_rsp_o.rvalid)
		else $error("no read response");
	chk_r_single: assert property (
		axil_rsp_o.rvalid && axil_req_i.rready |=> !axil_rsp_o.rvalid)
		else $error("read response repeated");
	chk_err_data_zero: assert property (
		axil_rsp_o.rvalid && axil_rsp_o.rresp == RESP_SLVERR |-> axil_rsp_o.rdata == WORD_RESET)
		else $error("refused read returned data");
	chk_irq_idle_reset: assert property (
		$rose(rst_n_i) |-> irq_out_n_o [*3])
		else $error("interrupt without enables");
	chk_dma_stop: assert property (
		dma_active_o && dma_stop_i |-> ##[1:2] !dma_active_o)
		else $error("transfer kept running after stop");
	cov_write: cover property (axil_rsp_o.bvalid && axil_req_i.bready);
	cov_slverr: cover property (axil_rsp_o.rvalid && axil_rsp_o.rresp == RESP_SLVERR);
	cov_irq: cover property ($fell(irq_out_n_o));
endmodule
bind usb_ctrl_interrupt_aggregator usb_irq_aggregator_checker chk (
	.ref_clk_i(ref_clk_i),
	.rst_n_i(rst_n_i),
	.axil_req_i(axil_req_i),
	.axil_rsp_o(axil_rsp_o),
	.dma_stop_i(dma_stop_i),
	.dma_active_o(dma_active_o),
	.irq_out_n_o(irq_out_n_o)
);

/* tb/usb_host_cpu_model.sv */
`timescale 1ns/100ps
module usb_host_cpu_model (
	input wire logic ref_clk_i,
	input wire usb_irq_pkg::axil_rsp_t rsp_i,
	output usb_irq_pkg::axil_req_t req_o
);
	import usb_irq_pkg::*;
	initial begin
		req_o = '0;
		req_o.wstrb = 4'hf;
	end
	// Writing 1 to a status flag clears it
	task automatic wr(input logic [7:0] idx, input logic [31:0] dat, output logic [1:0] resp);
		@(posedge ref_clk_i);
		req_o.awvalid <= 1'b1;
		req_o.awaddr <= {idx[5:0], 2'b00};
		req_o.wvalid <= 1'b1;
		req_o.wdata <= dat;
		req_o.bready <= 1'b1;
		do begin
			@(posedge ref_clk_i);
			if (rsp_i.awready)
				req_o.awvalid <= 1'b0;
			if (rsp_i.wready)
				req_o.wvalid <= 1'b0;
		end while (!rsp_i.bvalid);
		req_o.bready <= 1'b0;
		resp = rsp_i.bresp;
	endtask
	task automatic rd(input logic [7:0] idx, output logic [31:0] dat, output logic [1:0] resp);
		@(posedge ref_clk_i);
		req_o.arvalid <= 1'b1;
		req_o.araddr <= {idx[5:0], 2'b00};
		req_o.rready <= 1'b1;
		do begin
			@(posedge ref_clk_i);
			if (rsp_i.arready)
				req_o.arvalid <= 1'b0;
		end while (!rsp_i.rvalid);
		req_o.rready <= 1'b0;
		dat = rsp_i.rdata;
		resp = rsp_i.rresp;
	endtask
endmodule

/* tb/test_usb_ctrl_interrupt_aggregator.sv */
`timescale 1ns/100ps
module test_usb_ctrl_interrupt_aggregator;
	import usb_irq_pkg::*;
	logic ref_clk_i;
	logic rst_n_i;
	axil_req_t req;
	axil_rsp_t rsp;
	logic sleep, pm, in_dir, jempty, act, irq_n;
	logic [3:0] ev, hd;
	logic [7:0] dev;
	logic [2:0][7:0] lf;
	logic [5:0] hasd, full, emp;
	logic [7:0] ix [6];
	logic [7:0] mk [6];
	logic [31:0] d, v;
	logic [1:0] r;
	int m [32];
	int hb [3];
	int num_errors;
	int checks;
	usb_ctrl_interrupt_aggregator #(.AREAS(6)) dut (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.axil_req_i(req),
		.axil_rsp_o(rsp),
		.sleep_i(sleep),
		.pm_done_i(pm),
		.device_status_i(dev),
		.host_direct_i(hd),
		.host_frame_leaf_i(lf[0]),
		.host_ch0_leaf_i(lf[1]),
		.host_chr_leaf_i(lf[2]),
		.ram_fetch_done_i(ev[0]),
		.dma_beat_i(ev[1]),
		.dma_stop_i(ev[2]),
		.dma_end_done_i(ev[3]),
		.joined_in_dir_i(in_dir),
		.joined_fifo_empty_i(jempty),
		.area_has_data_i(hasd),
		.area_full_i(full),
		.area_empty_i(emp),
		.dma_active_o(act),
		.irq_out_n_o(irq_n)
	);
	usb_host_cpu_model host (
		.ref_clk_i(ref_clk_i),
		.rsp_i(rsp),
		.req_o(req)
	);
	initial begin
		ref_clk_i = 1'b0;
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end
	task automatic end_of_test();
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#500000;
		num_errors++;
		end_of_test();
	end
	task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic rc(input logic [7:0] i);
		host.rd(i, d, r);
		cmp("rdata", m[i], d);
		cmp("rresp", RESP_OKAY, r);
	endtask
	task automatic wc(input logic [7:0] i, input logic [31:0] x);
		host.wr(i, x, r);
		cmp("bresp", RESP_OKAY, r);
	endtask
	task automatic set(input logic [7:0] i, input logic [31:0] x);
		wc(i, x);
		m[i] = x;
	endtask
	task automatic pulse(input int k);
		ev[k] <= 1'b1;
		@(posedge ref_clk_i);
		ev[k] <= 1'b0;
		@(posedge ref_clk_i);
	endtask
	task automatic irq_is(input logic e);
		repeat (3) @(posedge ref_clk_i);
		cmp("irq_out_n", e, irq_n);
	endtask
	task automatic area(input logic [5:0] f, input logic [5:0] e, input logic [5:0] h, input int x);
		full <= f;
		emp <= e;
		hasd <= h;
		repeat (3) @(posedge ref_clk_i);
		m[IDX_FIFO_STATUS] = x;
		rc(IDX_FIFO_STATUS);
	endtask
	initial begin
		{sleep, pm, in_dir, jempty, ev, dev, hd, lf, hasd, full, emp} = '0;
		rst_n_i = 1'b0;
		num_errors = 0;
		checks = 0;
		foreach (m[i])
			m[i] = 0;
		ix = '{IDX_CPU_STATUS, IDX_FIFO_STATUS, IDX_MAIN_ENABLE, IDX_DEVICE_ENABLE,
			IDX_HOST_ENABLE, IDX_CPU_ENABLE};
		mk = '{8'h00, 8'h00, MAIN_ENABLE_MASK, DEVICE_ENABLE_MASK, HOST_ENABLE_MASK,
			CPU_ENABLE_MASK};
		hb = '{3, 1, 0};
		v = $urandom(32'h2817);
		repeat (16) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		for (int k = 0; k < 6; k++) begin
			rc(ix[k]);
			v = $urandom();
			wc(ix[k], v);
			m[ix[k]] = v & {24'h0, mk[k]};
			rc(ix[k]);
		end
		host.rd(8'h05, d, r);
		cmp("rresp", RESP_SLVERR, r);
		cmp("rdata", WORD_RESET, d);
		host.wr(8'h05, 32'hff, r);
		cmp("bresp", RESP_SLVERR, r);
		// Raise, mask in sleep, clear
		set(IDX_MAIN_ENABLE, 32'h20);
		set(IDX_CPU_ENABLE, 32'h80);
		pulse(0);
		irq_is(1'b0);
		m[IDX_CPU_STATUS] = 32'h80;
		m[IDX_TOP_STATUS] = 32'h20;
		rc(IDX_CPU_STATUS);
		rc(IDX_TOP_STATUS);
		wc(IDX_CPU_STATUS, 32'h7f);
		rc(IDX_CPU_STATUS);
		sleep <= 1'b1;
		irq_is(1'b1);
		set(IDX_MAIN_ENABLE, 32'h21);
		pm <= 1'b1;
		irq_is(1'b0);
		{pm, sleep} <= 2'b00;
		wc(IDX_CPU_STATUS, 32'h80);
		m[IDX_CPU_STATUS] = 0;
		m[IDX_TOP_STATUS] = 0;
		irq_is(1'b1);
		rc(IDX_TOP_STATUS);
		set(IDX_HOST_ENABLE, 32'h0b);
		for (int j = 0; j < 3; j++) begin
			set(8'(IDX_FRAME_ENABLE + j), 32'h01);
			for (int x = 2; x < 4; x++) begin
				lf[j] <= 8'(x);
				repeat (2) @(posedge ref_clk_i);
				m[IDX_HOST_STATUS] = (x == 3) ? (1 << hb[j]) : 0;
				rc(IDX_HOST_STATUS);
			end
			lf[j] <= 8'h00;
		end
		// Sleep keeps only the wake-capable group enables
		set(IDX_MAIN_ENABLE, 32'hc0);
		set(IDX_DEVICE_ENABLE, 32'h30);
		set(IDX_HOST_ENABLE, 32'h50);
		dev <= 8'h10;
		hd <= 4'h1;
		m[IDX_TOP_STATUS] = 32'hc0;
		irq_is(1'b0);
		rc(IDX_TOP_STATUS);
		sleep <= 1'b1;
		m[IDX_TOP_STATUS] = 0;
		irq_is(1'b1);
		rc(IDX_TOP_STATUS);
		dev <= 8'h20;
		hd <= 4'h4;
		m[IDX_TOP_STATUS] = 32'hc0;
		irq_is(1'b0);
		rc(IDX_TOP_STATUS);
		{sleep, dev, hd} <= '0;
		irq_is(1'b1);
		// Role and direction combinations; last one stopped mid-run
		wc(IDX_QUANTITY, 32'h2);
		for (int k = 0; k < 4; k++) begin
			in_dir <= k[0];
			jempty <= 1'b0;
			wc(IDX_CONTROL, 32'(4 + k / 2));
			@(posedge ref_clk_i);
			cmp("dma_active", 1'b1, act);
			pulse(1);
			if (k < 3)
				pulse(1);
			pulse(k == 3 ? 2 : 3);
			m[IDX_CPU_STATUS] = 1;
			m[IDX_FIFO_STATUS] = (k[1] != k[0]) ? 0 : 32'h80;
			rc(IDX_CPU_STATUS);
			rc(IDX_FIFO_STATUS);
			jempty <= 1'b1;
			m[IDX_FIFO_STATUS] = 32'h80;
			repeat (2) @(posedge ref_clk_i);
			rc(IDX_FIFO_STATUS);
			wc(IDX_CPU_STATUS, 32'hff);
			wc(IDX_FIFO_STATUS, 32'hff);
		end
		// Free run passes the quantity; a register stop ends it
		wc(IDX_CONTROL, 32'h6);
		repeat (3) pulse(1);
		m[IDX_COUNTER] = 3;
		rc(IDX_COUNTER);
		cmp("dma_active", 1'b1, act);
		wc(IDX_CONTROL, 32'h8);
		m[IDX_CPU_STATUS] = 1;
		m[IDX_FIFO_STATUS] = 32'h80;
		rc(IDX_CPU_STATUS);
		rc(IDX_FIFO_STATUS);
		wc(IDX_CPU_STATUS, 32'hff);
		wc(IDX_FIFO_STATUS, 32'hff);
		wc(IDX_CONTROL, 32'h400);
		area(6'h01, 6'h00, 6'h00, 0);
		area(6'h05, 6'h00, 6'h00, 2);
		area(6'h05, 6'h04, 6'h00, 3);
		area(6'h05, 6'h04, 6'h04, 7);
		area(6'h05, 6'h04, 6'h00, 7);
		wc(IDX_FIFO_STATUS, 32'h05);
		m[IDX_FIFO_STATUS] = 2;
		rc(IDX_FIFO_STATUS);
		set(IDX_FIFO_ENABLE, 32'h02);
		set(IDX_MAIN_ENABLE, 32'h10);
		m[IDX_TOP_STATUS] = 32'h10;
		rc(IDX_TOP_STATUS);
		irq_is(1'b0);
		end_of_test();
	end
endmodule
